/* File: hdl/zxd_top.sv */
// Function
// - Crossings are found after an always-on 80 Hz single-pole filter clocked 223 kHz.
// - Voltage crossing pin goes high on rising, low on falling filtered crossing.
// - Both crossing pins are unlatched and follow the waveform continuously.
// - Current pin follows phase channel; config bit 11 switches it to neutral.
// - Qualifying voltage crossing sets primary status bit 15.
// - Qualifying phase current crossing sets primary status bit 12.
// - Qualifying neutral current crossing sets neutral status bit 12.
// - Config bits 13:12 pick qualifying direction for all channels; reset 00 both.
// - Edge select affects only flags and interrupts, never the crossing pins.
// - Primary enable bit 15 lets voltage crossing pull interrupt pin low.
// - Primary enable bit 12 lets phase crossing pull interrupt pin low.
// - Neutral enable bit 12 lets neutral crossing pull interrupt pin low.
// - All crossing interrupt enables are clear after reset.
// - One 16-bit reload register at 0x100 sets timeout for all channels.
// - Each timeout counter decrements once per input clock divided by 256.
// - A detected crossing reloads that channel's timeout counter.
// - A counter reaching zero without crossing issues a timeout event.
// - Voltage and phase timeouts flag in primary status; neutral in neutral status.
// - Timeout enables: primary bits 14, 11; neutral bit 11; all clear at reset.
// - Inputs below full scale over 1250 produce no crossings, pin changes, crossing flags or crossing interrupts.
// - Below the floor, timeout counters still count down and expire.
`timescale 1ns/100ps
module zxd_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Sample inputs
    input wire logic signed [zxd_pkg::SAMPLE_W-1:0] voltSample,
    input wire logic signed [zxd_pkg::SAMPLE_W-1:0] phaseSample,
    input wire logic signed [zxd_pkg::SAMPLE_W-1:0] neutralSample,
    // Register port
    input wire logic [zxd_pkg::ADDR_W-1:0] regAddr,
    input wire logic regWrEn,
    input wire logic [31:0] regWrData,
    input wire logic regRdEn,
    output logic regRdValid,
    output logic [31:0] regRdData,
    // Pins
    output logic voltCrossPin,
    output logic currCrossPin,
    output logic irq_n
);

    typedef struct packed {
        logic [zxd_pkg::LPF_CNT_W-1:0] lpfCnt;
        logic [zxd_pkg::TMO_DIV_W-1:0] divCnt;
        logic [15:0] reload;
        logic [15:0] cfg;
        logic [31:0] enA;
        logic [31:0] enB;
        logic [31:0] statA;
        logic [31:0] statB;
        logic [zxd_pkg::NUM_CH-1:0][15:0] tmo;
        logic voltPin;
        logic currPin;
        logic irqN;
        logic rdValid;
        logic [31:0] rdData;
    } zxd_top_s;

    zxd_top_s s_reg;
    zxd_top_s s_next;

    logic lpfTick;
    logic tmoTick;
    logic [zxd_pkg::NUM_CH-1:0] xPos;
    logic [zxd_pkg::NUM_CH-1:0] xNeg;
    logic [zxd_pkg::NUM_CH-1:0] xLvl;
    logic signed [zxd_pkg::NUM_CH-1:0][zxd_pkg::SAMPLE_W-1:0] samples;

    assign samples = {neutralSample, phaseSample, voltSample};
    assign lpfTick = (s_reg.lpfCnt == zxd_pkg::LPF_CNT_W'(zxd_pkg::LPF_DIV - 1));
    assign tmoTick = (s_reg.divCnt == zxd_pkg::TMO_DIV_W'(zxd_pkg::TMO_DIV - 1));

    zxd_chan_if chIf[zxd_pkg::NUM_CH] ();

    genvar g;
    generate
        for (g = 0; g < zxd_pkg::NUM_CH; g++) begin : g_chan
            zxd_chan u_chan (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .lpfTick(lpfTick),
                .sample(samples[g]),
                .ch(chIf[g])
            );
            assign xPos[g] = chIf[g].posCross;
            assign xNeg[g] = chIf[g].negCross;
            assign xLvl[g] = chIf[g].level;
        end
    endgenerate

    // Edge select qualification shared by all three channels
    function automatic logic edgeQualifies(input logic pos, input logic neg, input logic [1:0] sel);
        logic q;
        q = 1'b0;
        unique case (sel)
            zxd_pkg::EDGE_BOTH: q = pos | neg;
            zxd_pkg::EDGE_POS: q = pos;
            zxd_pkg::EDGE_NEG: q = neg;
            zxd_pkg::EDGE_BOTH_ALT: q = pos | neg;
        endcase
        return q;
    endfunction

    logic [1:0] edgeSel;
    logic [zxd_pkg::NUM_CH-1:0] crossEvt;
    logic [zxd_pkg::NUM_CH-1:0] tmoEvt;
    logic [31:0] setA;
    logic [31:0] setB;
    logic clrA;
    logic clrB;

    assign edgeSel = s_reg.cfg[zxd_pkg::CFG_EDGE_HI:zxd_pkg::CFG_EDGE_LO];
    assign clrA = regRdEn && (regAddr == zxd_pkg::ADDR_PRI_STAT_RST);
    assign clrB = regRdEn && (regAddr == zxd_pkg::ADDR_NEU_STAT_RST);

    always_comb begin
        s_next = s_reg;
        crossEvt = '0;
        tmoEvt = '0;
        setA = '0;
        setB = '0;
        s_next.lpfCnt = lpfTick ? '0 : s_reg.lpfCnt + 1'b1;
        s_next.divCnt = tmoTick ? '0 : s_reg.divCnt + 1'b1;

        // Register writes; status registers are read-only
        if (regWrEn) begin
            unique case (regAddr)
                zxd_pkg::ADDR_TMO_RELOAD: s_next.reload = regWrData[15:0];
                zxd_pkg::ADDR_CONFIG: s_next.cfg = regWrData[15:0];
                zxd_pkg::ADDR_PRI_EN: s_next.enA = regWrData;
                zxd_pkg::ADDR_NEU_EN: s_next.enB = regWrData;
                default: begin
                end
            endcase
        end

        // Per-channel events and no-crossing counters
        for (int c = 0; c < zxd_pkg::NUM_CH; c++) begin
            crossEvt[c] = edgeQualifies(xPos[c], xNeg[c], edgeSel);
            if (xPos[c] || xNeg[c]) begin
                s_next.tmo[c] = s_reg.reload;
            end else if (tmoTick && s_reg.tmo[c] != '0) begin
                // Keeps running with no input at all
                s_next.tmo[c] = s_reg.tmo[c] - 1'b1;
                tmoEvt[c] = (s_reg.tmo[c] == 16'h0001);
            end
            // At zero the counter holds, so the event cannot repeat
        end

        setA[zxd_pkg::PRI_VCROSS_BIT] = crossEvt[zxd_pkg::CH_VOLT];
        setA[zxd_pkg::PRI_PCROSS_BIT] = crossEvt[zxd_pkg::CH_PHASE];
        setB[zxd_pkg::NEU_CROSS_BIT] = crossEvt[zxd_pkg::CH_NEUT];
        setA[zxd_pkg::PRI_VTMO_BIT] = tmoEvt[zxd_pkg::CH_VOLT];
        setA[zxd_pkg::PRI_PTMO_BIT] = tmoEvt[zxd_pkg::CH_PHASE];
        setB[zxd_pkg::NEU_TMO_BIT] = tmoEvt[zxd_pkg::CH_NEUT];

        // Sticky; an event in the clearing cycle survives the clear
        s_next.statA = (clrA ? '0 : s_reg.statA) | setA;
        s_next.statB = (clrB ? '0 : s_reg.statB) | setB;

        // Pins track levels, so edge select never reaches them
        s_next.voltPin = xLvl[zxd_pkg::CH_VOLT];
        s_next.currPin = s_reg.cfg[zxd_pkg::CFG_CURR_SEL_BIT]
            ? xLvl[zxd_pkg::CH_NEUT] : xLvl[zxd_pkg::CH_PHASE];

        // Level interrupt from enabled flags
        s_next.irqN = !(|(s_reg.statA & s_reg.enA) || |(s_reg.statB & s_reg.enB));

        // Read port; unmapped offsets read zero
        s_next.rdValid = regRdEn;
        if (regRdEn) begin
            unique case (regAddr)
                zxd_pkg::ADDR_TMO_RELOAD: s_next.rdData = {16'h0000, s_reg.reload};
                zxd_pkg::ADDR_CONFIG: s_next.rdData = {16'h0000, s_reg.cfg};
                zxd_pkg::ADDR_PRI_EN: s_next.rdData = s_reg.enA;
                zxd_pkg::ADDR_PRI_STAT: s_next.rdData = s_reg.statA;
                zxd_pkg::ADDR_PRI_STAT_RST: s_next.rdData = s_reg.statA;
                zxd_pkg::ADDR_NEU_EN: s_next.rdData = s_reg.enB;
                zxd_pkg::ADDR_NEU_STAT: s_next.rdData = s_reg.statB;
                zxd_pkg::ADDR_NEU_STAT_RST: s_next.rdData = s_reg.statB;
                default: s_next.rdData = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_reg.lpfCnt <= '0;
            s_reg.divCnt <= '0;
            s_reg.reload <= zxd_pkg::RELOAD_RST;
            s_reg.cfg <= zxd_pkg::CONFIG_RST;
            s_reg.enA <= zxd_pkg::EN_RST;
            s_reg.enB <= zxd_pkg::EN_RST;
            s_reg.statA <= zxd_pkg::STAT_RST;
            s_reg.statB <= zxd_pkg::STAT_RST;
            s_reg.tmo <= {zxd_pkg::NUM_CH{zxd_pkg::RELOAD_RST}};
            s_reg.voltPin <= 1'b0;
            s_reg.currPin <= 1'b0;
            s_reg.irqN <= 1'b1;
            s_reg.rdValid <= 1'b0;
            s_reg.rdData <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Unlatched pins come straight from flops
    assign voltCrossPin = s_reg.voltPin;
    assign currCrossPin = s_reg.currPin;
    assign irq_n = s_reg.irqN;
    assign regRdValid = s_reg.rdValid;
    assign regRdData = s_reg.rdData;

    a_volt_pin_rise:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        xPos[zxd_pkg::CH_VOLT] |=> voltCrossPin)
        else $error("Voltage pin did not rise after rising crossing");

    a_volt_pin_fall:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        xNeg[zxd_pkg::CH_VOLT] |=> !voltCrossPin)
        else $error("Voltage pin did not fall after falling crossing");

    a_curr_pin_select:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_reg.cfg[zxd_pkg::CFG_CURR_SEL_BIT] && xPos[zxd_pkg::CH_NEUT]
        |=> currCrossPin)
        else $error("Current pin ignored neutral channel selection");

    a_volt_flag_set:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        edgeSel == zxd_pkg::EDGE_BOTH && xNeg[zxd_pkg::CH_VOLT]
        |=> s_reg.statA[zxd_pkg::PRI_VCROSS_BIT])
        else $error("Voltage crossing flag not set");

    a_edge_pos_only:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        edgeSel == zxd_pkg::EDGE_POS && xNeg[zxd_pkg::CH_PHASE]
        && !s_reg.statA[zxd_pkg::PRI_PCROSS_BIT]
        |=> !s_reg.statA[zxd_pkg::PRI_PCROSS_BIT])
        else $error("Falling crossing flagged with rising-only select");

    a_neutral_flag_set:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        crossEvt[zxd_pkg::CH_NEUT] |=> s_reg.statB[zxd_pkg::NEU_CROSS_BIT])
        else $error("Neutral crossing flag not set");

    a_irq_follows_flags:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        |(s_reg.statA & s_reg.enA) || |(s_reg.statB & s_reg.enB) |=> !irq_n)
        else $error("Interrupt pin not low with enabled flag set");

    a_irq_has_cause:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        !irq_n |-> $past(|(s_reg.statA & s_reg.enA) || |(s_reg.statB & s_reg.enB)))
        else $error("Interrupt pin low without enabled flag");

    a_tmo_reload:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        xPos[zxd_pkg::CH_VOLT] || xNeg[zxd_pkg::CH_VOLT]
        |=> s_reg.tmo[zxd_pkg::CH_VOLT] == $past(s_reg.reload))
        else $error("Timeout counter not reloaded by crossing");

    a_tmo_decrement:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        tmoTick && !xPos[zxd_pkg::CH_PHASE] && !xNeg[zxd_pkg::CH_PHASE]
        && s_reg.tmo[zxd_pkg::CH_PHASE] != '0
        |=> s_reg.tmo[zxd_pkg::CH_PHASE] == $past(s_reg.tmo[zxd_pkg::CH_PHASE]) - 16'h0001)
        else $error("Timeout counter did not step on tick");

    a_tmo_expiry_flag:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        tmoTick && s_reg.tmo[zxd_pkg::CH_VOLT] == 16'h0001
        && !xPos[zxd_pkg::CH_VOLT] && !xNeg[zxd_pkg::CH_VOLT]
        |=> s_reg.statA[zxd_pkg::PRI_VTMO_BIT] && s_reg.tmo[zxd_pkg::CH_VOLT] == '0)
        else $error("Timeout expiry not flagged");

    a_tmo_hold_zero:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_reg.tmo[zxd_pkg::CH_NEUT] == '0 && !xPos[zxd_pkg::CH_NEUT] && !xNeg[zxd_pkg::CH_NEUT]
        |=> s_reg.tmo[zxd_pkg::CH_NEUT] == '0 && !tmoEvt[zxd_pkg::CH_NEUT])
        else $error("Expired timeout counter wrapped or refired");

    a_tick_period:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        tmoTick |=> !tmoTick [*8])
        else $error("Timeout tick repeated too soon");

    a_volt_pin_level:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        xLvl[zxd_pkg::CH_VOLT] |=> voltCrossPin)
        else $error("Voltage pin stopped following the waveform");

    a_phase_flag_set:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        edgeSel == zxd_pkg::EDGE_BOTH && xPos[zxd_pkg::CH_PHASE]
        |=> s_reg.statA[zxd_pkg::PRI_PCROSS_BIT])
        else $error("Phase crossing flag not set");

    a_edge_neg_only:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        edgeSel == zxd_pkg::EDGE_NEG && xPos[zxd_pkg::CH_VOLT]
        && !s_reg.statA[zxd_pkg::PRI_VCROSS_BIT]
        |=> !s_reg.statA[zxd_pkg::PRI_VCROSS_BIT])
        else $error("Rising crossing flagged with falling-only select");

    a_pins_ignore_edge:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        edgeSel == zxd_pkg::EDGE_NEG && xPos[zxd_pkg::CH_PHASE]
        && !s_reg.cfg[zxd_pkg::CFG_CURR_SEL_BIT]
        |=> currCrossPin)
        else $error("Edge select held back the current pin");

    a_phase_irq:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_reg.statA[zxd_pkg::PRI_PCROSS_BIT] && s_reg.enA[zxd_pkg::PRI_PCROSS_BIT]
        |=> !irq_n)
        else $error("Phase crossing interrupt not raised");

    a_phase_tmo_flag:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        tmoEvt[zxd_pkg::CH_PHASE] |=> s_reg.statA[zxd_pkg::PRI_PTMO_BIT])
        else $error("Phase timeout flag not set");

    a_neutral_tmo_flag:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        tmoEvt[zxd_pkg::CH_NEUT] |=> s_reg.statB[zxd_pkg::NEU_TMO_BIT])
        else $error("Neutral timeout flag not set");

    a_tmo_irq:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_reg.statB[zxd_pkg::NEU_TMO_BIT] && s_reg.enB[zxd_pkg::NEU_TMO_BIT]
        |=> !irq_n)
        else $error("Neutral timeout interrupt not raised");

    a_flag_sticky:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_reg.statA[zxd_pkg::PRI_VCROSS_BIT] && !clrA
        |=> s_reg.statA[zxd_pkg::PRI_VCROSS_BIT])
        else $error("Voltage crossing flag dropped without a clear");

endmodule // zxd_top

/* File: hdl/zxd_pkg.sv */
package zxd_pkg;

    // Clocking; the input clock of the block is clk_sys
    localparam int CLK_HZ = 100_000_000;
    localparam int LPF_HZ = 223_000;
    localparam int LPF_CORNER_HZ = 80;
    localparam int LPF_DIV = CLK_HZ / LPF_HZ;
    localparam int LPF_CNT_W = 9;
    // 2^-9 is the nearest power of two to 2*pi*80/223000
    localparam int LPF_SHIFT = 9;
    localparam int TMO_DIV = 256;
    localparam int TMO_DIV_W = 8;

    // Samples and the amplitude floor
    localparam int SAMPLE_W = 24;
    localparam int ACC_W = SAMPLE_W + LPF_SHIFT;
    localparam int FULL_SCALE = 2 ** (SAMPLE_W - 1);
    localparam int ZX_THR_RATIO = 1250;
    localparam logic [SAMPLE_W-1:0] ZX_THR = SAMPLE_W'(FULL_SCALE / ZX_THR_RATIO);

    // Channels
    localparam int NUM_CH = 3;
    localparam int CH_VOLT = 0;
    localparam int CH_PHASE = 1;
    localparam int CH_NEUT = 2;

    // Register offsets
    localparam int ADDR_W = 10;
    localparam logic [ADDR_W-1:0] ADDR_TMO_RELOAD = 10'h100;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = 10'h102;
    localparam logic [ADDR_W-1:0] ADDR_PRI_EN = 10'h22C;
    localparam logic [ADDR_W-1:0] ADDR_PRI_STAT = 10'h22D;
    localparam logic [ADDR_W-1:0] ADDR_PRI_STAT_RST = 10'h22E;
    localparam logic [ADDR_W-1:0] ADDR_NEU_EN = 10'h22F;
    localparam logic [ADDR_W-1:0] ADDR_NEU_STAT = 10'h230;
    localparam logic [ADDR_W-1:0] ADDR_NEU_STAT_RST = 10'h231;

    // Field positions
    localparam int CFG_CURR_SEL_BIT = 11;
    localparam int CFG_EDGE_LO = 12;
    localparam int CFG_EDGE_HI = 13;
    localparam int PRI_VCROSS_BIT = 15;
    localparam int PRI_VTMO_BIT = 14;
    localparam int PRI_PCROSS_BIT = 12;
    localparam int PRI_PTMO_BIT = 11;
    localparam int NEU_CROSS_BIT = 12;
    localparam int NEU_TMO_BIT = 11;

    // Edge select codes
    localparam logic [1:0] EDGE_BOTH = 2'h0;
    localparam logic [1:0] EDGE_POS = 2'h1;
    localparam logic [1:0] EDGE_NEG = 2'h2;
    localparam logic [1:0] EDGE_BOTH_ALT = 2'h3;

    // Reset values
    localparam logic [15:0] CONFIG_RST = 16'h0000;
    localparam logic [15:0] RELOAD_RST = 16'hFFFF;
    localparam logic [31:0] EN_RST = 32'h0000_0000;
    localparam logic [31:0] STAT_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        NEG_HALF = 2'b01,
        POS_HALF = 2'b10
    } zxd_half_e;

endpackage

/* File: hdl/zxd_chan_if.sv */
`timescale 1ns/100ps
interface zxd_chan_if;
    logic posCross;
    logic negCross;
    logic level;
    modport src (output posCross, output negCross, output level);
    modport snk (input posCross, input negCross, input level);
endinterface

/* File: hdl/zxd_chan.sv */
`timescale 1ns/100ps
module zxd_chan (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Sample path
    input wire logic lpfTick,
    input wire logic signed [zxd_pkg::SAMPLE_W-1:0] sample,
    // Crossing events
    zxd_chan_if.src ch
);

    typedef struct packed {
        logic signed [zxd_pkg::ACC_W-1:0] acc;
        logic [zxd_pkg::SAMPLE_W-1:0] peak;
        zxd_pkg::zxd_half_e half;
        logic posPulse;
        logic negPulse;
    } zxd_chan_s;

    zxd_chan_s s_reg;
    zxd_chan_s s_next;
    logic signed [zxd_pkg::SAMPLE_W-1:0] filt;
    logic [zxd_pkg::SAMPLE_W-1:0] mag;

    // Filtered value is the accumulator scaled back to sample width
    assign filt = s_reg.acc[zxd_pkg::ACC_W-1:zxd_pkg::LPF_SHIFT];
    assign mag = filt[zxd_pkg::SAMPLE_W-1] ? zxd_pkg::SAMPLE_W'(-filt) : filt;

    always_comb begin
        s_next = s_reg;
        s_next.posPulse = 1'b0;
        s_next.negPulse = 1'b0;
        // Always in the path, no bypass
        if (lpfTick) begin
            s_next.acc = s_reg.acc + zxd_pkg::ACC_W'(sample) - zxd_pkg::ACC_W'(filt);
        end
        // A half cycle counts only if its peak cleared the floor; noise never flips
        unique case (s_reg.half)
            zxd_pkg::NEG_HALF: begin
                if (!filt[zxd_pkg::SAMPLE_W-1] && filt != '0) begin
                    if (s_reg.peak >= zxd_pkg::ZX_THR) begin
                        s_next.posPulse = 1'b1;
                        s_next.half = zxd_pkg::POS_HALF;
                        s_next.peak = '0;
                    end
                end else if (mag > s_reg.peak) begin
                    s_next.peak = mag;
                end
            end
            zxd_pkg::POS_HALF: begin
                if (filt[zxd_pkg::SAMPLE_W-1]) begin
                    if (s_reg.peak >= zxd_pkg::ZX_THR) begin
                        s_next.negPulse = 1'b1;
                        s_next.half = zxd_pkg::NEG_HALF;
                        s_next.peak = '0;
                    end
                end else if (mag > s_reg.peak) begin
                    s_next.peak = mag;
                end
            end
            default: begin
                s_next.half = zxd_pkg::NEG_HALF;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{acc: '0, peak: '0, half: zxd_pkg::NEG_HALF, posPulse: 1'b0, negPulse: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign ch.posCross = s_reg.posPulse;
    assign ch.negCross = s_reg.negPulse;
    assign ch.level = (s_reg.half == zxd_pkg::POS_HALF);

    a_pulse_needs_peak:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_next.posPulse || s_next.negPulse |-> s_reg.peak >= zxd_pkg::ZX_THR)
        else $error("Crossing issued below the amplitude floor");

endmodule // zxd_chan

/* File: dv/zxd_wave_src.sv */
`timescale 1ns/100ps
module zxd_wave_src #(
    parameter int HALF = 3584
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Wave control, zero amplitude means a silent channel
    input wire logic signed [zxd_pkg::SAMPLE_W-1:0] amp,
    // Sample out
    output logic signed [zxd_pkg::SAMPLE_W-1:0] sample
);
    int cnt;
    logic posHalf;
    // A short first half keeps the filtered wave centred on zero
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n || amp == '0) begin
            cnt <= HALF / 2;
            posHalf <= 1'b1;
        end else if (cnt <= 1) begin
            cnt <= HALF;
            posHalf <= ~posHalf;
        end else begin
            cnt <= cnt - 1;
        end
    end
    assign sample = posHalf ? amp : -amp;
endmodule // zxd_wave_src

/* File: dv/testbench.sv */
`timescale 1ns/100ps
module testbench;
    localparam logic signed [23:0] AMP = 24'sh400000;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic signed [23:0] ampV = '0;
    logic signed [23:0] ampP = '0;
    logic signed [23:0] ampN = '0;
    logic signed [23:0] voltSample;
    logic signed [23:0] phaseSample;
    logic signed [23:0] neutralSample;
    logic [9:0] regAddr = '0;
    logic regWrEn = 1'b0;
    logic [31:0] regWrData = '0;
    logic regRdEn = 1'b0;
    logic regRdValid;
    logic [31:0] regRdData;
    logic voltCrossPin;
    logic currCrossPin;
    logic irq_n;
    logic [31:0] rdVal;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;

    always #5 clk_sys = ~clk_sys;

    zxd_wave_src srcV (.clk_sys(clk_sys), .rst_n(rst_n), .amp(ampV), .sample(voltSample));
    zxd_wave_src srcP (.clk_sys(clk_sys), .rst_n(rst_n), .amp(ampP), .sample(phaseSample));
    zxd_wave_src srcN (.clk_sys(clk_sys), .rst_n(rst_n), .amp(ampN), .sample(neutralSample));

    zxd_top DUT (
        .clk_sys(clk_sys), .rst_n(rst_n),
        .voltSample(voltSample), .phaseSample(phaseSample), .neutralSample(neutralSample),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdValid(regRdValid), .regRdData(regRdData),
        .voltCrossPin(voltCrossPin), .currCrossPin(currCrossPin), .irq_n(irq_n)
    );

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [9:0] addr, input logic [31:0] data);
        @(posedge clk_sys);
        regAddr <= addr;
        regWrData <= data;
        regWrEn <= 1'b1;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
    endtask

    // Answer is registered, so it is looked at one cycle after the strobe
    task automatic rd(input logic [9:0] addr, output logic [31:0] data);
        @(posedge clk_sys);
        regAddr <= addr;
        regRdEn <= 1'b1;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        #1;
        check("read valid", 32'h1, {31'h0, regRdValid});
        data = regRdData;
    endtask

    // Bounded wait for the voltage pin to reach a level
    task automatic waitPin(input logic val);
        int n;
        n = 0;
        while (voltCrossPin !== val && n < 20000) begin
            settle(1);
            n++;
        end
        check("volt pin", {31'h0, val}, {31'h0, voltCrossPin});
    endtask

    task automatic t_reset();
        logic [9:0] addrs [7] = '{10'h100, 10'h102, 10'h22C, 10'h22D, 10'h22F, 10'h230, 10'h3FF};
        check("irq idle", 32'h1, {31'h0, irq_n});
        foreach (addrs[i]) begin
            rd(addrs[i], rdVal);
            check("reset value", (i == 0) ? 32'hFFFF : 32'h0, rdVal);
        end
        wr(10'h22D, 32'hFFFF_FFFF);
        rd(10'h22D, rdVal);
        check("status read only", 32'h0, rdVal);
    endtask

    task automatic t_cross();
        wr(10'h100, 32'h14);
        ampV <= AMP;
        ampP <= AMP;
        ampN <= AMP;
        waitPin(1'b1);
        check("curr pin phase", 32'h1, {31'h0, currCrossPin});
        check("irq masked", 32'h1, {31'h0, irq_n});
        rd(10'h22D, rdVal);
        check("primary flags", 32'h9000, rdVal & 32'hD800);
        rd(10'h230, rdVal);
        check("neutral flags", 32'h1000, rdVal & 32'h1800);
        wr(10'h22C, 32'h8000);
        settle(3);
        check("irq volt", 32'h0, {31'h0, irq_n});
        wr(10'h22C, 32'h1000);
        settle(3);
        check("irq phase", 32'h0, {31'h0, irq_n});
        wr(10'h22C, 32'h0);
        wr(10'h22F, 32'h1000);
        settle(3);
        check("irq neutral", 32'h0, {31'h0, irq_n});
        rd(10'h231, rdVal);
        settle(3);
        check("irq cleared", 32'h1, {31'h0, irq_n});
        wr(10'h22F, 32'h0);
        ampN <= '0;
        wr(10'h102, 32'h800);
        waitPin(1'b0);
        check("curr pin neutral", 32'h1, {31'h0, currCrossPin});
    endtask

    // Each edge code over one full wave; reload outlasts a half cycle
    task automatic t_edge();
        logic [1:0] code;
        for (int c = 0; c < 4; c++) begin
            code = c[1:0];
            wr(10'h102, {18'h0, code, 12'h0});
            rd(10'h22E, rdVal);
            waitPin(1'b1);
            rd(10'h22E, rdVal);
            check("rise flag", (code == 2'h2) ? 32'h0 : 32'h8000, rdVal & 32'hC800);
            waitPin(1'b0);
            rd(10'h22E, rdVal);
            check("fall flag", (code == 2'h1) ? 32'h0 : 32'h8000, rdVal & 32'hC800);
        end
    endtask

    task automatic t_timeout();
        @(posedge clk_sys);
        ampV <= '0;
        ampP <= '0;
        wr(10'h22C, 32'h4000);
        wr(10'h22F, 32'h0800);
        settle(6000);
        check("pin silent", 32'h0, {31'h0, voltCrossPin});
        check("irq timeout", 32'h0, {31'h0, irq_n});
        rd(10'h22E, rdVal);
        check("primary timeouts", 32'h4800, rdVal & 32'hD800);
        rd(10'h231, rdVal);
        check("neutral timeout", 32'h0800, rdVal & 32'h1800);
        settle(3000);
        rd(10'h22D, rdVal);
        check("no refire", 32'h0, rdVal & 32'hD800);
        check("irq released", 32'h1, {31'h0, irq_n});
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_cross();
        t_edge();
        t_timeout();
        test_done();
    end

    // Whole run needs about 50000 cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_errors++;
            test_done();
        end
    end
endmodule // testbench
